// >>> rtl/pfta_params.svh
// Constants of the program flash and table access block
// Function
// - 32K by 16-bit words fetched by PC
// - Code, tables and vectors share one array
// - Bank picked by two low bank bits
// - Execution starts at address zero after reset
// - Table address from both pointer registers
// - Low byte to data memory, high to hold
// - Short table forms reach sector zero only
// - Last-page forms use fixed last page
// - Table instructions take two cycles
// - Serial programming over data and clock lines
// - Self-programming may target any location
// - Erase clears one 64-word page
// - Write programs 64 words per operation
// - Read returns one word per operation
`ifndef PFTA_PARAMS_SVH
`define PFTA_PARAMS_SVH
`define PFTA_ADDR_W 15
`define PFTA_DATA_W 16
`define PFTA_DEPTH 32768
`define PFTA_PC_W 13
`define PFTA_BANK_W 2
`define PFTA_BANK_RESET 2'h0
`define PFTA_RESET_VECTOR 15'h0000
`define PFTA_TBHP_W 7
`define PFTA_LAST_PAGE 7'h7F
`define PFTA_DM_SECT_W 2
`define PFTA_DM_OFS_W 8
`define PFTA_SECTOR0 2'h0
`define PFTA_PAGE_W 6
`define PFTA_PAGE_NUM_W 9
`define PFTA_PAGE_WORDS 64
`define PFTA_PAGE_LAST 6'h3F
`define PFTA_ERASED 16'hFFFF
`define PFTA_ICP_CNT_W 4
`define PFTA_ICP_LAST 4'hF
`endif

// >>> rtl/pfta_pkg.sv
// Types of the program flash and table access block
`include "pfta_params.svh"
package pfta_pkg;
    typedef enum logic [1:0] {TAB_IDLE, TAB_ADDR, TAB_DATA} pfta_tab_state_t;
    typedef enum logic [1:0] {IAP_IDLE, IAP_PROG, IAP_RD, IAP_RDW} pfta_iap_state_t;
    typedef enum logic [1:0] {IAP_CMD_WRITE, IAP_CMD_ERASE, IAP_CMD_READ, IAP_CMD_NONE} pfta_iap_cmd_t;
    typedef enum logic [1:0] {ICP_HDR, ICP_WDATA, ICP_RDATA} pfta_icp_state_t;
endpackage

// >>> rtl/pfta_mem_if.sv
// Port bundle between the controller and the flash word array
`timescale 1ns/1ps
`include "pfta_params.svh"
interface pfta_mem_if;
    logic [`PFTA_ADDR_W-1:0] rd_addr; // Read address, data one clock later
    logic [`PFTA_DATA_W-1:0] rd_data; // Registered read data
    logic wr_en; // Word write strobe
    logic [`PFTA_ADDR_W-1:0] wr_addr; // Write address
    logic [`PFTA_DATA_W-1:0] wr_data; // Write data
    modport ctrl (output rd_addr, input rd_data, output wr_en, output wr_addr, output wr_data);
    modport array (input rd_addr, output rd_data, input wr_en, input wr_addr, input wr_data);
endinterface

// >>> rtl/pfta_flash_array.sv
// Flash word array holding code, tables and vectors
`timescale 1ns/1ps
`include "pfta_params.svh"
module pfta_flash_array (
    // Clock
    input wire logic clk,
    // Controller side
    pfta_mem_if.array mem
);
    // One array for instructions and constant data alike
    logic [`PFTA_DATA_W-1:0] words [`PFTA_DEPTH];

    // Synchronous write, registered read; no reset so it maps onto RAM
    always_ff @(posedge clk) begin
        if (mem.wr_en) begin
            words[mem.wr_addr] <= mem.wr_data;
        end
        mem.rd_data <= words[mem.rd_addr];
    end
endmodule

// >>> rtl/pfta_top.sv
// Program flash controller: fetch, table reads, self-programming, serial programming
`timescale 1ns/1ps
`include "pfta_params.svh"
module pfta_top import pfta_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Instruction fetch
    input wire logic fetch_req,
    input wire logic [`PFTA_PC_W-1:0] fetch_pc,
    output logic [`PFTA_DATA_W-1:0] fetch_word,
    output logic fetch_valid,
    // Bank select register
    input wire logic bank_wr,
    input wire logic [7:0] bank_wdata,
    output logic [`PFTA_BANK_W-1:0] program_bank_select,
    // Table pointers and high-byte hold
    input wire logic tblp_wr,
    input wire logic tbhp_wr,
    input wire logic [7:0] ptr_wdata,
    input wire logic thh_wr,
    input wire logic [7:0] thh_wdata,
    output logic [7:0] table_high_byte_hold,
    // Table read command and data-memory write
    input wire logic tab_req,
    input wire logic tab_last_page,
    input wire logic extended_table_read,
    input wire logic [`PFTA_DM_SECT_W-1:0] tab_dest_sector,
    input wire logic [`PFTA_DM_OFS_W-1:0] tab_dest_ofs,
    output logic tab_ready,
    output logic dm_wr_en,
    output logic [`PFTA_DM_SECT_W+`PFTA_DM_OFS_W-1:0] dm_wr_addr,
    output logic [7:0] dm_wr_data,
    // Self-programming
    input wire logic iap_req,
    input wire pfta_iap_cmd_t iap_cmd,
    input wire logic [`PFTA_ADDR_W-1:0] iap_addr,
    input wire logic iap_buf_wr,
    input wire logic [`PFTA_DATA_W-1:0] iap_buf_wdata,
    output logic iap_ready,
    output logic iap_busy,
    output logic iap_done,
    output logic [`PFTA_DATA_W-1:0] iap_rdata,
    // Serial programming pins
    input wire logic in_circuit_programming,
    input wire logic prog_serial_clock_line,
    input wire logic prog_serial_data_line_in,
    output logic prog_serial_data_line_out,
    output logic prog_serial_data_line_oe_n
);
    pfta_mem_if mem (); // Array port bundle
    pfta_tab_state_t tab_state_reg; // Table read sequencer
    pfta_iap_state_t iap_state_reg; // Self-programming sequencer
    pfta_icp_state_t icp_state_reg; // Serial frame phase
    logic boot_reg; // First fetch after reset pending
    logic fetch_pend_reg; // Fetch read in flight
    logic [`PFTA_DATA_W-1:0] fetch_word_reg;
    logic fetch_valid_reg;
    logic [`PFTA_BANK_W-1:0] bank_reg;
    logic [7:0] tblp_reg;
    logic [`PFTA_TBHP_W-1:0] tbhp_reg;
    logic [7:0] thh_reg;
    logic [`PFTA_ADDR_W-1:0] tab_addr_reg; // Latched table address
    logic [`PFTA_DM_SECT_W+`PFTA_DM_OFS_W-1:0] dest_reg; // Latched destination
    logic dm_wr_en_reg;
    logic [`PFTA_DM_SECT_W+`PFTA_DM_OFS_W-1:0] dm_wr_addr_reg;
    logic [7:0] dm_wr_data_reg;
    logic [`PFTA_DATA_W-1:0] wbuf [`PFTA_PAGE_WORDS]; // Page write buffer
    logic [`PFTA_PAGE_W-1:0] wbuf_ptr_reg; // Buffer fill pointer
    logic [`PFTA_PAGE_NUM_W-1:0] iap_page_reg;
    logic [`PFTA_PAGE_W-1:0] iap_cnt_reg; // Word within page
    logic iap_erase_reg; // Erase rather than write
    logic [`PFTA_ADDR_W-1:0] iap_addr_reg;
    logic iap_done_reg;
    logic [`PFTA_DATA_W-1:0] iap_rdata_reg;
    logic [1:0] en_sync_reg; // Two sync stages
    logic [2:0] ck_sync_reg; // Two sync stages plus history for edge
    logic [1:0] da_sync_reg;
    logic icp_act; // Programming mode, synchronised
    logic icp_rise; // Rising serial clock, synchronised
    logic [`PFTA_ICP_CNT_W-1:0] icp_cnt_reg;
    logic [`PFTA_DATA_W-1:0] icp_sh_reg; // Shift register both ways
    logic [`PFTA_ADDR_W-1:0] icp_addr_reg;
    logic icp_rd_pend_reg, icp_wr_pend_reg, icp_rd_back_reg;
    logic grant_fetch, grant_icp_rd, grant_icp_wr; // Array arbitration
    logic tab_go, iap_go;

    // Pin synchronisers; only the second stage onward is looked at
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            en_sync_reg <= 2'h0;
            ck_sync_reg <= 3'h0;
            da_sync_reg <= 2'h0;
        end else begin
            en_sync_reg <= {en_sync_reg[0], in_circuit_programming};
            ck_sync_reg <= {ck_sync_reg[1:0], prog_serial_clock_line};
            da_sync_reg <= {da_sync_reg[0], prog_serial_data_line_in};
        end
    end
    assign icp_act = en_sync_reg[1];
    assign icp_rise = ck_sync_reg[1] & ~ck_sync_reg[2];

    // Command acceptance; serial programming locks out the core
    assign tab_ready = (tab_state_reg == TAB_IDLE) && (iap_state_reg == IAP_IDLE) && !icp_act;
    assign iap_ready = tab_ready && !tab_req;
    assign tab_go = tab_req && tab_ready;
    assign iap_go = iap_req && iap_ready && (iap_cmd != IAP_CMD_NONE);

    // Array arbitration: table, then self-programming, then serial, then fetch
    always_comb begin
        mem.wr_en = 1'b0;
        mem.wr_addr = icp_addr_reg;
        mem.wr_data = icp_sh_reg;
        grant_icp_wr = 1'b0;
        grant_icp_rd = 1'b0;
        grant_fetch = 1'b0;
        if (iap_state_reg == IAP_PROG) begin
            // Whole page in one operation
            mem.wr_en = 1'b1;
            mem.wr_addr = {iap_page_reg, iap_cnt_reg};
            mem.wr_data = iap_erase_reg ? `PFTA_ERASED : wbuf[iap_cnt_reg];
        end else if (icp_wr_pend_reg) begin
            mem.wr_en = 1'b1;
            grant_icp_wr = 1'b1;
        end
        if (tab_state_reg == TAB_ADDR) begin
            mem.rd_addr = tab_addr_reg;
        end else if (iap_state_reg == IAP_RD) begin
            mem.rd_addr = iap_addr_reg;
        end else if (icp_rd_pend_reg) begin
            mem.rd_addr = icp_addr_reg;
            grant_icp_rd = 1'b1;
        end else begin
            // Boot fetch forced to the reset entry, then bank plus PC
            mem.rd_addr = boot_reg ? `PFTA_RESET_VECTOR : {bank_reg, fetch_pc};
            grant_fetch = fetch_req && !icp_act && (iap_state_reg != IAP_PROG);
        end
    end

    // Instruction fetch pipeline, two clocks from request to word
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            boot_reg <= 1'b1;
            fetch_pend_reg <= 1'b0;
            fetch_valid_reg <= 1'b0;
            fetch_word_reg <= '0;
        end else begin
            fetch_pend_reg <= grant_fetch;
            fetch_valid_reg <= fetch_pend_reg;
            if (grant_fetch) begin
                boot_reg <= 1'b0;
            end
            if (fetch_pend_reg) begin
                fetch_word_reg <= mem.rd_data;
            end
        end
    end

    // Bank select and table pointers, written by the core
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bank_reg <= `PFTA_BANK_RESET;
            tblp_reg <= 8'h00;
            tbhp_reg <= '0;
        end else begin
            if (bank_wr) begin
                bank_reg <= bank_wdata[`PFTA_BANK_W-1:0];
            end
            if (tblp_wr) begin
                tblp_reg <= ptr_wdata;
            end
            if (tbhp_wr) begin
                tbhp_reg <= ptr_wdata[`PFTA_TBHP_W-1:0];
            end
        end
    end

    // Table read sequencer: address cycle then data cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tab_state_reg <= TAB_IDLE;
            tab_addr_reg <= '0;
            dest_reg <= '0;
        end else begin
            case (tab_state_reg)
                TAB_IDLE: begin
                    if (tab_go) begin
                        // Last-page forms ignore the high pointer
                        tab_addr_reg <= {tab_last_page ? `PFTA_LAST_PAGE : tbhp_reg, tblp_reg};
                        // Short forms are confined to sector zero
                        dest_reg <= {extended_table_read ? tab_dest_sector : `PFTA_SECTOR0, tab_dest_ofs};
                        tab_state_reg <= TAB_ADDR;
                    end
                end
                TAB_ADDR: tab_state_reg <= TAB_DATA;
                TAB_DATA: tab_state_reg <= TAB_IDLE;
                default: tab_state_reg <= TAB_IDLE;
            endcase
        end
    end

    // Table result: low byte out to data memory, high byte held
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dm_wr_en_reg <= 1'b0;
            dm_wr_addr_reg <= '0;
            dm_wr_data_reg <= 8'h00;
            thh_reg <= 8'h00;
        end else begin
            dm_wr_en_reg <= (tab_state_reg == TAB_DATA);
            if (tab_state_reg == TAB_DATA) begin
                dm_wr_addr_reg <= dest_reg;
                dm_wr_data_reg <= mem.rd_data[7:0];
                thh_reg <= mem.rd_data[15:8];
            end else if (thh_wr) begin
                // Shared register; software must save it around handlers
                thh_reg <= thh_wdata;
            end
        end
    end

    // Page write buffer, filled word by word with a wrapping pointer
    always_ff @(posedge clk) begin
        if (iap_buf_wr) begin
            wbuf[wbuf_ptr_reg] <= iap_buf_wdata;
        end
    end

    // Buffer pointer restarts when a page operation begins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wbuf_ptr_reg <= '0;
        end else if (iap_go) begin
            wbuf_ptr_reg <= '0;
        end else if (iap_buf_wr) begin
            wbuf_ptr_reg <= wbuf_ptr_reg + 1'b1;
        end
    end

    // Self-programming sequencer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            iap_state_reg <= IAP_IDLE;
            iap_page_reg <= '0;
            iap_cnt_reg <= '0;
            iap_erase_reg <= 1'b0;
            iap_addr_reg <= '0;
            iap_done_reg <= 1'b0;
            iap_rdata_reg <= '0;
        end else begin
            iap_done_reg <= 1'b0;
            case (iap_state_reg)
                IAP_IDLE: begin
                    if (iap_go) begin
                        // Any location may be chosen
                        iap_addr_reg <= iap_addr;
                        iap_page_reg <= iap_addr[`PFTA_ADDR_W-1:`PFTA_PAGE_W];
                        iap_cnt_reg <= '0;
                        iap_erase_reg <= (iap_cmd == IAP_CMD_ERASE);
                        iap_state_reg <= (iap_cmd == IAP_CMD_READ) ? IAP_RD : IAP_PROG;
                    end
                end
                IAP_PROG: begin
                    iap_cnt_reg <= iap_cnt_reg + 1'b1;
                    if (iap_cnt_reg == `PFTA_PAGE_LAST) begin
                        iap_state_reg <= IAP_IDLE;
                        iap_done_reg <= 1'b1;
                    end
                end
                IAP_RD: iap_state_reg <= IAP_RDW;
                IAP_RDW: begin
                    iap_rdata_reg <= mem.rd_data;
                    iap_done_reg <= 1'b1;
                    iap_state_reg <= IAP_IDLE;
                end
                default: iap_state_reg <= IAP_IDLE;
            endcase
        end
    end

    // Serial programming: 16-bit header {rw, address}, then 16 data bits, MSB first
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            icp_state_reg <= ICP_HDR;
            icp_cnt_reg <= '0;
            icp_sh_reg <= '0;
            icp_addr_reg <= '0;
            icp_rd_pend_reg <= 1'b0;
            icp_wr_pend_reg <= 1'b0;
            icp_rd_back_reg <= 1'b0;
        end else begin
            icp_rd_back_reg <= grant_icp_rd;
            if (grant_icp_rd) begin
                icp_rd_pend_reg <= 1'b0;
            end
            if (grant_icp_wr) begin
                icp_wr_pend_reg <= 1'b0;
            end
            if (icp_rd_back_reg) begin
                icp_sh_reg <= mem.rd_data;
            end
            if (!icp_act) begin
                // Leaving the mode drops any half frame
                icp_state_reg <= ICP_HDR;
                icp_cnt_reg <= '0;
            end else if (icp_rise) begin
                icp_cnt_reg <= icp_cnt_reg + 1'b1;
                case (icp_state_reg)
                    ICP_HDR: begin
                        icp_sh_reg <= {icp_sh_reg[`PFTA_DATA_W-2:0], da_sync_reg[1]};
                        if (icp_cnt_reg == `PFTA_ICP_LAST) begin
                            icp_addr_reg <= {icp_sh_reg[`PFTA_ADDR_W-2:0], da_sync_reg[1]};
                            if (icp_sh_reg[`PFTA_ADDR_W-1]) begin
                                icp_state_reg <= ICP_WDATA;
                            end else begin
                                icp_rd_pend_reg <= 1'b1;
                                icp_state_reg <= ICP_RDATA;
                            end
                        end
                    end
                    ICP_WDATA: begin
                        icp_sh_reg <= {icp_sh_reg[`PFTA_DATA_W-2:0], da_sync_reg[1]};
                        if (icp_cnt_reg == `PFTA_ICP_LAST) begin
                            icp_wr_pend_reg <= 1'b1;
                            icp_state_reg <= ICP_HDR;
                        end
                    end
                    ICP_RDATA: begin
                        icp_sh_reg <= {icp_sh_reg[`PFTA_DATA_W-2:0], 1'b0};
                        if (icp_cnt_reg == `PFTA_ICP_LAST) begin
                            icp_state_reg <= ICP_HDR;
                        end
                    end
                    default: icp_state_reg <= ICP_HDR;
                endcase
            end
        end
    end

    // Data pin driven only while a read word is shifted out
    assign prog_serial_data_line_out = icp_sh_reg[`PFTA_DATA_W-1];
    assign prog_serial_data_line_oe_n = !(icp_act && (icp_state_reg == ICP_RDATA));

    pfta_flash_array u_array (
        .clk(clk),
        .mem(mem)
    );

    // Outputs
    assign fetch_word = fetch_word_reg;
    assign fetch_valid = fetch_valid_reg;
    assign program_bank_select = bank_reg;
    assign table_high_byte_hold = thh_reg;
    assign dm_wr_en = dm_wr_en_reg;
    assign dm_wr_addr = dm_wr_addr_reg;
    assign dm_wr_data = dm_wr_data_reg;
    assign iap_busy = (iap_state_reg != IAP_IDLE);
    assign iap_done = iap_done_reg;
    assign iap_rdata = iap_rdata_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_tab_walk;
        (tab_state_reg == TAB_ADDR) ##1 (tab_state_reg == TAB_DATA) ##1 dm_wr_en;
    endsequence
    property p_tab_two_cycles;
        tab_go |=> s_tab_walk;
    endproperty
    a_tab_two_cycles: assert property (p_tab_two_cycles) else $error("table read not done in two cycles");
    property p_short_sector0;
        tab_go && !extended_table_read |-> ##3 (dm_wr_addr[`PFTA_DM_SECT_W+`PFTA_DM_OFS_W-1:`PFTA_DM_OFS_W] == 2'h0);
    endproperty
    a_short_sector0: assert property (p_short_sector0) else $error("short form left sector zero");
    property p_high_byte;
        (tab_state_reg == TAB_DATA) |=> (thh_reg == $past(mem.rd_data[15:8])) && (dm_wr_data == $past(mem.rd_data[7:0]));
    endproperty
    a_high_byte: assert property (p_high_byte) else $error("table bytes misrouted");
    property p_last_page;
        tab_go && tab_last_page |=> (mem.rd_addr == {7'h7F, $past(tblp_reg)});
    endproperty
    a_last_page: assert property (p_last_page) else $error("last page not used");
    property p_tab_addr;
        tab_go && !tab_last_page |=> (mem.rd_addr == {$past(tbhp_reg), $past(tblp_reg)});
    endproperty
    a_tab_addr: assert property (p_tab_addr) else $error("table address not from pointers");
    property p_reset_fetch;
        grant_fetch && boot_reg |-> (mem.rd_addr == 15'h0000);
    endproperty
    a_reset_fetch: assert property (p_reset_fetch) else $error("first fetch not at zero");
    property p_bank;
        grant_fetch && !boot_reg |-> (mem.rd_addr[14:13] == program_bank_select) ##2 fetch_valid;
    endproperty
    a_bank: assert property (p_bank) else $error("fetch bank or latency wrong");
    sequence s_prog_walk;
        (iap_busy && mem.wr_en)[*8] ##56 (iap_busy && mem.wr_en && mem.wr_addr[5:0] == 6'h3F) ##1 iap_done;
    endsequence
    property p_page_op;
        iap_go && (iap_cmd != IAP_CMD_READ) |=> s_prog_walk;
    endproperty
    a_page_op: assert property (p_page_op) else $error("page operation not 64 words");
    property p_read_one;
        iap_go && (iap_cmd == IAP_CMD_READ) |-> ##3 (iap_done && !iap_busy && !mem.wr_en);
    endproperty
    a_read_one: assert property (p_read_one) else $error("read not one word in three clocks");
    property p_icp_drive;
        !prog_serial_data_line_oe_n |-> icp_act && (icp_state_reg == ICP_RDATA);
    endproperty
    a_icp_drive: assert property (p_icp_drive) else $error("data pin driven outside read");
endmodule

// >>> test/pfta_core_model.sv
// Core-side model that issues instruction fetches and table reads
`timescale 1ns/1ps
module pfta_core_model (
    // Clock
    input wire logic clk,
    // Fetch
    output logic fetch_req,
    output logic [12:0] fetch_pc,
    input wire logic fetch_valid,
    input wire logic [15:0] fetch_word,
    // Table read
    output logic tab_req,
    output logic tab_last_page,
    output logic extended_table_read,
    output logic [1:0] tab_dest_sector,
    output logic [7:0] tab_dest_ofs,
    input wire logic tab_ready,
    input wire logic dm_wr_en
);
    // Idle core: no requests
    initial begin
        fetch_req = 1'b0;
        fetch_pc = 13'h0000;
        {tab_req, tab_last_page, extended_table_read, tab_dest_sector, tab_dest_ofs} = 13'h0000;
    end

    // One fetch; the pc lines are scrambled once released, so stale values never look valid
    task automatic fetch(input logic [12:0] pc, output logic [15:0] w);
        int n;
        @(negedge clk);
        fetch_req = 1'b1;
        fetch_pc = pc;
        for (n = 0; n < 20 && fetch_valid !== 1'b1; n++) @(negedge clk);
        w = (fetch_valid === 1'b1) ? fetch_word : 16'hXXXX;
        fetch_req = 1'b0;
        fetch_pc = ~pc;
        repeat (4) @(negedge clk);
    endtask

    // One table read, never overlapped by a second one; returns cycles from acceptance to write
    task automatic tab_read(input logic lp, ext, input logic [1:0] sec, input logic [7:0] ofs,
                            output int cyc);
        @(negedge clk);
        tab_req = 1'b1;
        tab_last_page = lp;
        extended_table_read = ext;
        tab_dest_sector = sec;
        tab_dest_ofs = ofs;
        for (cyc = 0; cyc < 20 && tab_ready !== 1'b1; cyc++) @(negedge clk);
        @(negedge clk);
        tab_req = 1'b0;
        tab_dest_ofs = ~ofs;
        for (cyc = 1; cyc < 20 && dm_wr_en !== 1'b1; cyc++) @(negedge clk);
    endtask
endmodule

// >>> test/program_flash_table_access_tb.sv
// Self-checking bench for the program flash and table access block
`timescale 1ns/1ps
module program_flash_table_access_tb import pfta_pkg::*;;
    logic clk, resetn, fetch_req, fetch_valid, bank_wr, tblp_wr, tbhp_wr, tab_req, tab_last_page;
    logic extended_table_read, tab_ready, dm_wr_en, iap_req, iap_buf_wr, iap_ready, iap_busy, iap_done;
    logic [12:0] fetch_pc;
    logic [15:0] fetch_word, iap_buf_wdata, iap_rdata, w;
    logic [7:0] bank_wdata, ptr_wdata, table_high_byte_hold, tab_dest_ofs, dm_wr_data;
    logic [1:0] program_bank_select, tab_dest_sector;
    logic [9:0] dm_wr_addr;
    logic [14:0] iap_addr;
    pfta_iap_cmd_t iap_cmd;
    logic icp_en, icp_ck, icp_da, ser_out, ser_oe_n;
    int fail_count = 0;
    int compares = 0;
    int n;

    // Serial programming pins are driven by the bench alone
    pfta_top u_dut (.clk, .resetn, .fetch_req, .fetch_pc, .fetch_word, .fetch_valid,
        .bank_wr, .bank_wdata, .program_bank_select, .tblp_wr, .tbhp_wr, .ptr_wdata,
        .thh_wr(1'b0), .thh_wdata(8'h00), .table_high_byte_hold, .tab_req, .tab_last_page,
        .extended_table_read, .tab_dest_sector, .tab_dest_ofs, .tab_ready, .dm_wr_en, .dm_wr_addr,
        .dm_wr_data, .iap_req, .iap_cmd, .iap_addr, .iap_buf_wr, .iap_buf_wdata, .iap_ready,
        .iap_busy, .iap_done, .iap_rdata, .in_circuit_programming(icp_en), .prog_serial_clock_line(icp_ck),
        .prog_serial_data_line_in(icp_da), .prog_serial_data_line_out(ser_out),
        .prog_serial_data_line_oe_n(ser_oe_n));
    pfta_core_model u_core (.clk, .fetch_req, .fetch_pc, .fetch_valid, .fetch_word, .tab_req,
        .tab_last_page, .extended_table_read, .tab_dest_sector, .tab_dest_ofs, .tab_ready, .dm_wr_en);

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Compare one value; X never matches
    task automatic chk(input string nm, input logic [15:0] exp, got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Counts, verdict and end of run
    task automatic stop_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Reset held for two cycles
    task automatic do_reset();
        @(negedge clk);
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
    endtask

    // One-cycle write strobe: sel 0 bank, 1 low pointer, 2 high pointer
    task automatic wr_reg(input int sel, input logic [7:0] d);
        @(negedge clk);
        {bank_wr, tblp_wr, tbhp_wr} = 3'h4 >> sel;
        bank_wdata = d;
        ptr_wdata = d;
        @(negedge clk);
        {bank_wr, tblp_wr, tbhp_wr} = 3'h0;
    endtask

    // Self-programming command; a page write loads 64 buffer words first
    task automatic in_application_programming(input pfta_iap_cmd_t c, input logic [14:0] a, input logic [15:0] base);
        for (n = 0; n < 64 && c == IAP_CMD_WRITE; n++) begin
            @(negedge clk);
            iap_buf_wr = 1'b1;
            iap_buf_wdata = base + n[15:0];
        end
        @(negedge clk);
        iap_buf_wr = 1'b0;
        iap_req = 1'b1;
        iap_cmd = c;
        iap_addr = a;
        for (n = 0; n < 20 && iap_ready !== 1'b1; n++) @(negedge clk);
        @(negedge clk);
        iap_req = 1'b0;
        chk("iap busy", 16'h0001, 16'(iap_busy));
        for (n = 1; n < 100 && iap_done !== 1'b1; n++) @(negedge clk);
    endtask

    // Program page 0 and the last page, read one word back
    task automatic t_program();
        in_application_programming(IAP_CMD_WRITE, 15'h0000, 16'h1000);
        chk("write cycles", 16'h0041, 16'(n));
        in_application_programming(IAP_CMD_WRITE, 15'h7F00, 16'h2000);
        chk("write last cycles", 16'h0041, 16'(n));
        in_application_programming(IAP_CMD_READ, 15'h0005, 16'h0000);
        chk("read cycles", 16'h0003, 16'(n));
        chk("read word", 16'h1005, iap_rdata);
        $display("test program done");
    endtask

    // Short, extended and last-page table reads
    task automatic t_table();
        wr_reg(1, 8'h06);
        wr_reg(2, 8'h00);
        u_core.tab_read(1'b0, 1'b0, 2'h3, 8'h55, n);
        chk("table cycles", 16'h0003, 16'(n));
        chk("dm addr short", 16'h0055, 16'(dm_wr_addr));
        chk("dm data", 16'h0006, 16'(dm_wr_data));
        chk("hold", 16'h0010, 16'(table_high_byte_hold));
        wr_reg(2, 8'h7F);
        u_core.tab_read(1'b0, 1'b1, 2'h2, 8'hAA, n);
        chk("table cycles", 16'h0003, 16'(n));
        chk("dm addr ext", 16'h02AA, 16'(dm_wr_addr));
        chk("hold ext", 16'h0020, 16'(table_high_byte_hold));
        wr_reg(2, 8'h00);
        wr_reg(1, 8'h07);
        u_core.tab_read(1'b1, 1'b0, 2'h0, 8'h10, n);
        chk("table cycles", 16'h0003, 16'(n));
        chk("last page data", 16'h0007, 16'(dm_wr_data));
        chk("last page hold", 16'h0020, 16'(table_high_byte_hold));
        $display("test table done");
    endtask

    // Reset vector and bank-extended fetches
    task automatic t_fetch();
        do_reset();
        chk("bank reset", 16'h0000, 16'(program_bank_select));
        u_core.fetch(13'h0005, w);
        chk("reset fetch", 16'h1000, w);
        u_core.fetch(13'h0005, w);
        chk("fetch bank0", 16'h1005, w);
        wr_reg(0, 8'hFF);
        chk("bank bits", 16'h0003, 16'(program_bank_select));
        u_core.fetch(13'h1F06, w);
        chk("fetch bank3", 16'h2006, w);
        $display("test fetch done");
    endtask

    // Page erase leaves erased words
    task automatic t_erase();
        in_application_programming(IAP_CMD_ERASE, 15'h0012, 16'h0000);
        chk("erase cycles", 16'h0041, 16'(n));
        in_application_programming(IAP_CMD_READ, 15'h003F, 16'h0000);
        chk("erased word", 16'hFFFF, iap_rdata);
        $display("test erase done");
    endtask

    // Serial write of A5C3h to 0123h, then read back; pins move every 4 clocks
    task automatic t_serial();
        logic [63:0] f;
        logic [15:0] r;
        f = 64'h8123_A5C3_0123_0000;
        icp_en = 1'b1;
        for (n = 0; n < 64; n++) begin
            icp_da = f[63-n];
            repeat (4) @(negedge clk);
            r = {r[14:0], ser_out};
            chk("serial oe_n", 16'(n < 48), 16'(ser_oe_n));
            icp_ck = 1'b1;
            repeat (4) @(negedge clk);
            icp_ck = 1'b0;
        end
        chk("serial word", 16'hA5C3, r);
        icp_en = 1'b0;
        $display("test serial done");
    endtask

    // Main sequence
    initial begin
        resetn = 1'b0;
        {bank_wr, tblp_wr, tbhp_wr, iap_req, iap_buf_wr} = 5'h00;
        {bank_wdata, ptr_wdata, iap_buf_wdata, iap_addr} = 47'h0;
        iap_cmd = IAP_CMD_NONE;
        {icp_en, icp_ck, icp_da} = 3'h0;
        do_reset();
        t_program();
        t_table();
        t_fetch();
        t_serial();
        t_erase();
        stop_test();
    end
endmodule
